// File: rtl/usb_host_port_pkg.sv
// Summary of operation
// [RQ1] read-only 16-bit channel summary, upper bits zero
// [RQ2] summary follows per-channel flags, never written directly
// [RQ3] 16-bit channel mask, reset zero, gates summary
// [RQ4] channels irq bit when summary and mask overlap
// [RQ5] port change flags raise port irq, write-one clears
// [RQ6] speed code and D+/D- line levels read-only
// [RQ7] nonzero test field selects port test signalling
// [RQ8] port power bit, writable, resets off
// [RQ9] reset bit drives port reset while set
// [RQ10] software holds reset about 10 ms extra
// [RQ11] suspend write-one sets, stops frame starts only
// [RQ12] suspend cleared on wakeup or disconnect
// [RQ13] resume bit drives resume until software clears
// [RQ14] remote wakeup starts resume and sets bit
// [RQ15] change flags on overcurrent and enable changes
// [RQ16] enable set by finished reset, cleared otherwise
// [RQ17] connect detected flag and connect status bit
// [RQ18] channel enable set by software, cleared on stop
// [RQ19] channel abort stops channel, halted flag confirms
// [RQ20] periodic channel runs only in chosen frame parity
// [RQ21] per-frame transactions field, software programs nonzero
// [RQ22] two-bit transfer type field selects transfer kind
// [RQ23] channel address, speed, direction, endpoint, packet size
// [RQ24] clearing channel flags clears summary and global bit
// [RQ25] channel event flags device-set, write-one clears
package usb_host_port_pkg;
   localparam int ADDR_W = 9; // byte address bits decoded
   // register byte offsets
   localparam logic [8:0] OFS_SUMMARY = 9'h000;
   localparam logic [8:0] OFS_MASK = 9'h004;
   localparam logic [8:0] OFS_PORT = 9'h008;
   localparam logic [8:0] OFS_GIRQ = 9'h00c;
   localparam logic [8:0] OFS_CHAR_BASE = 9'h100; // 16 words
   localparam logic [8:0] OFS_EVT_BASE = 9'h140; // 16 words
   // port control/status bit positions
   localparam int P_CONN_STATE = 0;
   localparam int P_CONN_DET = 1;
   localparam int P_EN = 2;
   localparam int P_EN_CHG = 3;
   localparam int P_OVC = 4;
   localparam int P_OVC_CHG = 5;
   localparam int P_RESUME = 6;
   localparam int P_SUSPEND = 7;
   localparam int P_RESET = 8;
   localparam int P_LINE_LO = 10;
   localparam int P_POWER = 12;
   localparam int P_TEST_LO = 13;
   localparam int P_SPEED_LO = 17;
   // attached device speed codes
   localparam logic [1:0] SPEED_NONE = 2'h0;
   localparam logic [1:0] SPEED_FULL = 2'h1;
   localparam logic [1:0] SPEED_LOW = 2'h2;
   // port test selections
   typedef enum logic [3:0] {
      TEST_OFF = 4'h0,
      TEST_J = 4'h1,
      TEST_K = 4'h2,
      TEST_SE0_NAK = 4'h3,
      TEST_PACKET = 4'h4,
      TEST_FORCE_EN = 4'h5
   } test_mode_t;
   // channel characteristics bit positions
   localparam int C_ENABLE = 31;
   localparam int C_ABORT = 30;
   localparam int C_ODD = 29;
   localparam int C_ADDR_LO = 22;
   localparam int C_MC_LO = 20;
   localparam int C_TYPE_LO = 18;
   localparam int C_LS = 17;
   localparam int C_DIR = 15;
   localparam int C_EP_LO = 11;
   localparam int C_MPS_LO = 0;
   localparam logic [31:0] CHAR_RW_MASK = 32'h3ffe_ffff; // plain rw fields
   typedef enum logic [1:0] {
      XFER_CONTROL = 2'h0,
      XFER_ISO = 2'h1,
      XFER_BULK = 2'h2,
      XFER_INTR = 2'h3
   } xfer_type_t;
   // channel event flag bits
   localparam int EVT_W = 2;
   localparam int E_DONE = 0;
   localparam int E_HALT = 1;
   // global status bits
   localparam int G_CHAN = 0;
   localparam int G_PORT = 1;
   localparam logic [15:0] MASK_RESET = 16'h0000;
endpackage : usb_host_port_pkg

// File: rtl/change_flag.sv
`timescale 1ns/1ps
// sticky flag set by a change of a level, cleared by a write of one
module change_flag #(
   parameter bit RISE_ONLY = 1'b0 // 1: only a rising edge sets the flag
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic level_i,
   input wire logic clear_i,
   output logic flag_o
);
   typedef struct packed {
      logic prev; // level seen last cycle
      logic flag; // sticky flag
   } cf_state_t;

   cf_state_t s_reg;
   cf_state_t s_next;
   logic hit;

   // edge detect and sticky update; a change in the clear cycle still sets
   always_comb begin
      hit = RISE_ONLY ? (level_i & ~s_reg.prev) : (level_i ^ s_reg.prev);
      s_next.prev = level_i;
      s_next.flag = (s_reg.flag & ~clear_i) | hit;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign flag_o = s_reg.flag;
endmodule : change_flag

// File: rtl/usb_host_port_channel_ctrl.sv
`timescale 1ns/1ps
// host port control/status and channel characteristics behind wishbone
module usb_host_port_channel_ctrl #(
   parameter int NUM_CHAN = 16 // host channels
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [usb_host_port_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // port side status from the transceiver
   input wire logic connect_i,
   input wire logic low_speed_i,
   input wire logic dp_i,
   input wire logic dm_i,
   input wire logic overcurrent_i,
   input wire logic remote_wakeup_i,
   // port side controls
   output logic port_power_o,
   output logic port_reset_o,
   output logic port_suspend_o,
   output logic port_resume_o,
   output logic [3:0] port_test_o,
   output logic port_enabled_o,
   // channel engine side
   input wire logic frame_odd_i,
   input wire logic [NUM_CHAN-1:0] chan_done_i,
   input wire logic [NUM_CHAN-1:0] chan_halted_i,
   input wire logic [3:0] chan_sel_i,
   output logic [31:0] chan_cfg_o,
   output logic [NUM_CHAN-1:0] chan_go_o,
   output logic [NUM_CHAN-1:0] chan_abort_o,
   // global interrupt status bits
   output logic chan_irq_o,
   output logic port_irq_o
);
   typedef struct packed {
      logic ack; // bus answer
      logic [31:0] rdata; // read data
      logic [15:0] irq_mask; // channel mask
      logic [15:0] summary; // channel summary
      logic reset_drive; // port reset
      logic suspend; // port suspend
      logic resume; // resume signalling
      logic power; // port power
      logic enabled; // port enabled
      logic ovc_active; // overcurrent status
      logic conn_state; // attached device present
      logic [3:0] test_sel; // test selection
      logic [1:0] speed; // attached speed
      logic [1:0] line; // {dm, dp}
      logic chan_irq; // global channel bit
      logic port_irq; // global port bit
      logic [NUM_CHAN-1:0][31:0] chars; // channel characteristics
      logic [NUM_CHAN-1:0][usb_host_port_pkg::EVT_W-1:0] events; // channel flags
      logic [NUM_CHAN-1:0] go; // channel may run now
      logic [31:0] cfg_out; // selected channel word
   } state_t;

   state_t s_reg;
   state_t s_next;

   // change flags from the edge detectors
   logic conn_det_flag;
   logic en_chg_flag;
   logic ovc_chg_flag;

   // bus decode
   logic req;
   logic wr;
   logic [31:0] bmask; // byte lanes enabled
   logic [31:0] w1; // written ones, lane masked
   logic port_w;
   logic disconnect;
   logic [3:0] idx;
   logic [31:0] c; // channel word under update
   logic [usb_host_port_pkg::EVT_W-1:0] e; // channel flags under update
   logic periodic;

   // expand byte selects to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction : lane_mask

   // one 16-word bank of 64 bytes
   function automatic logic in_bank(input logic [8:0] a, input logic [8:0] base);
      return a[8:6] == base[8:6];
   endfunction : in_bank

   // the three change flags feeding the port interrupt
   change_flag #(.RISE_ONLY(1'b1)) u_conn_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(connect_i),
      .clear_i(port_w & w1[usb_host_port_pkg::P_CONN_DET]),
      .flag_o(conn_det_flag)
   ); // RQ17
   change_flag #(.RISE_ONLY(1'b0)) u_en_chg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(s_reg.enabled),
      .clear_i(port_w & w1[usb_host_port_pkg::P_EN_CHG]),
      .flag_o(en_chg_flag)
   ); // RQ15
   change_flag #(.RISE_ONLY(1'b0)) u_ovc_chg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(s_reg.ovc_active),
      .clear_i(port_w & w1[usb_host_port_pkg::P_OVC_CHG]),
      .flag_o(ovc_chg_flag)
   ); // RQ15

   // next-state logic for the whole block
   always_comb begin
      s_next = s_reg;
      c = '0;
      e = '0;
      periodic = 1'b0;
      // a request is taken while ack is low; ack follows one cycle later
      req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      wr = req & wb_we_i;
      bmask = lane_mask(wb_sel_i);
      w1 = wb_dat_i & bmask;
      idx = wb_adr_i[5:2];
      port_w = wr && (wb_adr_i == usb_host_port_pkg::OFS_PORT);
      disconnect = s_reg.conn_state & ~connect_i;
      s_next.ack = req;

      // channel mask, byte-lane merge
      if (wr && wb_adr_i == usb_host_port_pkg::OFS_MASK) begin
         s_next.irq_mask = (s_reg.irq_mask & ~bmask[15:0]) | w1[15:0]; // RQ3
      end

      // plain port status sampled from the pins
      s_next.conn_state = connect_i; // RQ17
      s_next.ovc_active = overcurrent_i; // RQ15
      s_next.line = {dm_i, dp_i}; // RQ6
      if (!connect_i) begin
         s_next.speed = usb_host_port_pkg::SPEED_NONE;
      end else if (low_speed_i) begin
         s_next.speed = usb_host_port_pkg::SPEED_LOW; // RQ6
      end else begin
         s_next.speed = usb_host_port_pkg::SPEED_FULL; // RQ6
      end

      // writable port fields
      if (port_w) begin
         if (bmask[usb_host_port_pkg::P_POWER]) begin
            s_next.power = wb_dat_i[usb_host_port_pkg::P_POWER]; // RQ8
         end
         if (bmask[usb_host_port_pkg::P_RESET]) begin
            s_next.reset_drive = wb_dat_i[usb_host_port_pkg::P_RESET]; // RQ9
         end
         // test field straddles lanes 1 and 2; take it only with both
         if (bmask[usb_host_port_pkg::P_TEST_LO] && bmask[usb_host_port_pkg::P_TEST_LO+3]) begin
            s_next.test_sel = wb_dat_i[usb_host_port_pkg::P_TEST_LO +: 4]; // RQ7
         end
         if (bmask[usb_host_port_pkg::P_RESUME]) begin
            s_next.resume = wb_dat_i[usb_host_port_pkg::P_RESUME]; // RQ13
         end
         if (w1[usb_host_port_pkg::P_SUSPEND]) begin
            s_next.suspend = 1'b1; // RQ11
         end
      end

      // wakeup from the far end starts resume; it wins over a write of zero
      if (remote_wakeup_i) begin
         s_next.resume = 1'b1; // RQ14
      end
      // suspend ends on wakeup or on loss of the device
      if (remote_wakeup_i || disconnect) begin
         s_next.suspend = 1'b0; // RQ12
      end

      // enable comes only from a finished reset with a healthy device
      if (s_reg.reset_drive && !s_next.reset_drive && connect_i && !overcurrent_i) begin
         s_next.enabled = 1'b1; // RQ16
      end
      // clearing causes beat the set: a port is never enabled into a fault
      if (overcurrent_i || disconnect || (port_w && w1[usb_host_port_pkg::P_EN])) begin
         s_next.enabled = 1'b0; // RQ16
      end

      // port interrupt from the change flags only, never from enable itself
      s_next.port_irq = conn_det_flag | en_chg_flag | ovc_chg_flag; // RQ5

      // per-channel characteristics and event flags
      for (int n = 0; n < NUM_CHAN; n++) begin
         c = s_reg.chars[n];
         e = s_reg.events[n];
         // software clear of the flags goes first so a new event wins
         if (wr && in_bank(wb_adr_i, usb_host_port_pkg::OFS_EVT_BASE) && idx == n[3:0]) begin
            e = e & ~w1[usb_host_port_pkg::EVT_W-1:0]; // RQ25
         end
         // channel stops: enable drops, abort is done
         if (chan_done_i[n]) begin
            c[usb_host_port_pkg::C_ENABLE] = 1'b0; // RQ18
            e[usb_host_port_pkg::E_DONE] = 1'b1; // RQ25
         end
         if (chan_halted_i[n]) begin
            c[usb_host_port_pkg::C_ENABLE] = 1'b0; // RQ18
            c[usb_host_port_pkg::C_ABORT] = 1'b0; // RQ19
            e[usb_host_port_pkg::E_HALT] = 1'b1; // RQ19
         end
         // software write after the stop, so a restart in that cycle holds
         if (wr && in_bank(wb_adr_i, usb_host_port_pkg::OFS_CHAR_BASE) && idx == n[3:0]) begin
            c = (c & ~(usb_host_port_pkg::CHAR_RW_MASK & bmask))
               | (w1 & usb_host_port_pkg::CHAR_RW_MASK); // RQ23 RQ21
            if (w1[usb_host_port_pkg::C_ENABLE]) begin
               c[usb_host_port_pkg::C_ENABLE] = 1'b1; // RQ18
            end
            if (w1[usb_host_port_pkg::C_ABORT]) begin
               c[usb_host_port_pkg::C_ABORT] = 1'b1; // RQ19
            end
         end
         s_next.chars[n] = c;
         s_next.events[n] = e;
         // summary bit follows the channel's own flags only
         s_next.summary[n] = |e; // RQ2
         // periodic kinds wait for the frame parity they ask for
         periodic = (c[usb_host_port_pkg::C_TYPE_LO +: 2] == usb_host_port_pkg::XFER_ISO)
            || (c[usb_host_port_pkg::C_TYPE_LO +: 2] == usb_host_port_pkg::XFER_INTR); // RQ22
         s_next.go[n] = c[usb_host_port_pkg::C_ENABLE] & ~c[usb_host_port_pkg::C_ABORT]
            & (~periodic | (c[usb_host_port_pkg::C_ODD] == frame_odd_i)); // RQ20
      end

      // global channel bit tracks the masked summary both ways
      s_next.chan_irq = |(s_next.summary & s_next.irq_mask); // RQ4 RQ24

      // selected channel word for the transaction engine
      s_next.cfg_out = s_reg.chars[chan_sel_i];

      // read mux; unmapped addresses answer zero
      s_next.rdata = '0;
      if (req && !wb_we_i) begin
         if (wb_adr_i == usb_host_port_pkg::OFS_SUMMARY) begin
            s_next.rdata = {16'h0000, s_reg.summary}; // RQ1
         end else if (wb_adr_i == usb_host_port_pkg::OFS_MASK) begin
            s_next.rdata = {16'h0000, s_reg.irq_mask}; // RQ3
         end else if (wb_adr_i == usb_host_port_pkg::OFS_PORT) begin
            s_next.rdata[usb_host_port_pkg::P_CONN_STATE] = s_reg.conn_state;
            s_next.rdata[usb_host_port_pkg::P_CONN_DET] = conn_det_flag;
            s_next.rdata[usb_host_port_pkg::P_EN] = s_reg.enabled;
            s_next.rdata[usb_host_port_pkg::P_EN_CHG] = en_chg_flag;
            s_next.rdata[usb_host_port_pkg::P_OVC] = s_reg.ovc_active;
            s_next.rdata[usb_host_port_pkg::P_OVC_CHG] = ovc_chg_flag;
            s_next.rdata[usb_host_port_pkg::P_RESUME] = s_reg.resume; // RQ13
            s_next.rdata[usb_host_port_pkg::P_SUSPEND] = s_reg.suspend; // RQ11
            s_next.rdata[usb_host_port_pkg::P_RESET] = s_reg.reset_drive;
            s_next.rdata[usb_host_port_pkg::P_LINE_LO +: 2] = s_reg.line;
            s_next.rdata[usb_host_port_pkg::P_POWER] = s_reg.power;
            s_next.rdata[usb_host_port_pkg::P_TEST_LO +: 4] = s_reg.test_sel;
            s_next.rdata[usb_host_port_pkg::P_SPEED_LO +: 2] = s_reg.speed;
         end else if (wb_adr_i == usb_host_port_pkg::OFS_GIRQ) begin
            s_next.rdata[usb_host_port_pkg::G_CHAN] = s_reg.chan_irq;
            s_next.rdata[usb_host_port_pkg::G_PORT] = s_reg.port_irq;
         end else if (in_bank(wb_adr_i, usb_host_port_pkg::OFS_CHAR_BASE)) begin
            s_next.rdata = s_reg.chars[idx];
         end else if (in_bank(wb_adr_i, usb_host_port_pkg::OFS_EVT_BASE)) begin
            s_next.rdata[usb_host_port_pkg::EVT_W-1:0] = s_reg.events[idx];
         end
      end
   end

   // single state register; every field starts cleared
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.irq_mask <= usb_host_port_pkg::MASK_RESET; // RQ3
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs are flop bits of the state record
   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.rdata;
   assign port_power_o = s_reg.power; // RQ8
   assign port_reset_o = s_reg.reset_drive; // RQ9
   assign port_suspend_o = s_reg.suspend; // RQ11
   assign port_resume_o = s_reg.resume; // RQ13
   assign port_test_o = s_reg.test_sel; // RQ7
   assign port_enabled_o = s_reg.enabled;
   assign chan_cfg_o = s_reg.cfg_out;
   assign chan_go_o = s_reg.go;
   assign chan_irq_o = s_reg.chan_irq;
   assign port_irq_o = s_reg.port_irq;

   // abort bits straight out of the characteristic words
   always_comb begin
      for (int n = 0; n < NUM_CHAN; n++) begin
         chan_abort_o[n] = s_reg.chars[n][usb_host_port_pkg::C_ABORT]; // RQ19
      end
   end
endmodule : usb_host_port_channel_ctrl

// File: tb/usb_attached_device_model.sv
`timescale 1ns/1ps
// attached usb peripheral: attach, speed, line levels and wakeup
module usb_attached_device_model (
   input wire logic attach_i, // device plugged in
   input wire logic slow_i, // low-speed device
   input wire logic wake_req_i, // one-cycle wakeup request
   input wire logic bus_reset_i, // host drives reset
   input wire logic bus_resume_i, // host drives resume
   input wire logic bus_suspend_i, // host port suspended
   output logic connect_o,
   output logic low_speed_o,
   output logic dp_o,
   output logic dm_o,
   output logic wakeup_o
);
   // line levels follow host signalling; host pull-downs when detached
   always_comb begin
      connect_o = attach_i;
      low_speed_o = attach_i & slow_i;
      if (!attach_i || bus_reset_i) begin
         {dm_o, dp_o} = 2'h0; // se0 on the wire
      end else if (bus_resume_i) begin
         {dm_o, dp_o} = slow_i ? 2'h1 : 2'h2; // k state
      end else begin
         {dm_o, dp_o} = slow_i ? 2'h2 : 2'h1; // j idle
      end
      // a real device only wakes a suspended bus
      wakeup_o = attach_i & bus_suspend_i & wake_req_i;
   end
endmodule : usb_attached_device_model

// File: tb/usb_host_port_channel_ctrl_checker.sv
`timescale 1ns/1ps
// port-level checks of the host port and channel block
module usb_host_port_channel_ctrl_checker #(
   parameter int NUM_CHAN = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic connect_i,
   input wire logic overcurrent_i,
   input wire logic remote_wakeup_i,
   input wire logic port_reset_o,
   input wire logic port_suspend_o,
   input wire logic port_resume_o,
   input wire logic port_enabled_o,
   input wire logic [NUM_CHAN-1:0] chan_halted_i,
   input wire logic [NUM_CHAN-1:0] chan_go_o,
   input wire logic [NUM_CHAN-1:0] chan_abort_o,
   input wire logic port_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("stray read data");
   a_conn_irq: assert property ($rose(connect_i) |-> ##[1:3] port_irq_o)
      else $error("no connect irq");
   a_enable_cause: assert property ($rose(port_enabled_o) |->
      $past(port_reset_o) || $past(port_reset_o, 2))
      else $error("enable without reset");
   a_ovc_disable: assert property (overcurrent_i |-> ##[1:2] !port_enabled_o)
      else $error("enabled in overcurrent");
   a_disc_disable: assert property (!connect_i |-> ##[1:2] !port_enabled_o)
      else $error("enabled while detached");
   a_disc_unsusp: assert property ($fell(connect_i) |-> ##[1:2] !port_suspend_o)
      else $error("suspended while detached");
   a_wake_resume: assert property (remote_wakeup_i |=> port_resume_o && !port_suspend_o)
      else $error("no resume on wakeup");
   a_resume_hold: assert property (port_resume_o && !wb_stb_i && !$past(wb_stb_i)
      |=> port_resume_o)
      else $error("resume dropped");
   for (genvar k = 0; k < NUM_CHAN; k++) begin : g_chan
      a_halt_stops: assert property (chan_halted_i[k]
         |-> ##[1:3] !chan_abort_o[k] && !chan_go_o[k])
         else $error("halted channel active");
   end
endmodule : usb_host_port_channel_ctrl_checker
bind usb_host_port_channel_ctrl usb_host_port_channel_ctrl_checker #(.NUM_CHAN(NUM_CHAN))
   chk (.*);

// File: tb/usb_host_port_channel_ctrl_tb.sv
`timescale 1ns/1ps
module usb_host_port_channel_ctrl_tb;
   localparam logic [8:0] sum_a = usb_host_port_pkg::OFS_SUMMARY;
   localparam logic [8:0] msk_a = usb_host_port_pkg::OFS_MASK;
   localparam logic [8:0] prt_a = usb_host_port_pkg::OFS_PORT;
   localparam logic [8:0] evt_a = usb_host_port_pkg::OFS_EVT_BASE;
   localparam logic [8:0] chr_a = usb_host_port_pkg::OFS_CHAR_BASE + 9'h8; // channel 2
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [8:0] wb_adr_i;
   logic [3:0] wb_sel_i, chan_sel_i, port_test_o;
   logic [31:0] wb_dat_i, wb_dat_o, chan_cfg_o, rdata;
   logic connect_i, low_speed_i, dp_i, dm_i, overcurrent_i, remote_wakeup_i, frame_odd_i;
   logic port_power_o, port_reset_o, port_suspend_o, port_resume_o, port_enabled_o;
   logic [15:0] chan_done_i, chan_halted_i, chan_go_o, chan_abort_o;
   logic chan_irq_o, port_irq_o, attach, slow, wake_req;
   int num_errors = 0;
   int cmp_count = 0;
   usb_host_port_channel_ctrl #(.NUM_CHAN(16)) dut (.*);
   usb_attached_device_model peer (.attach_i(attach), .slow_i(slow), .wake_req_i(wake_req),
      .bus_reset_i(port_reset_o), .bus_resume_i(port_resume_o), .bus_suspend_i(port_suspend_o),
      .connect_o(connect_i), .low_speed_o(low_speed_i), .dp_o(dp_i), .dm_o(dm_i),
      .wakeup_o(remote_wakeup_i));
   // free-running 40 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // classic single cycle; held until ack is sampled high at an edge
   task automatic bus(input logic [8:0] a, input logic w, input logic [3:0] s,
         input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      @(posedge clk_i iff wb_ack_o === 1'b1);
      rdata = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic rchk(input string n, input logic [8:0] a, input logic [31:0] m,
         input logic [31:0] e);
      bus(a, 1'b0, 4'hf, 32'h0);
      check(n, rdata & m, e);
   endtask : rchk
   task automatic t_regs;
      rchk("summary", sum_a, '1, 0);
      rchk("mask", msk_a, '1, 0);
      rchk("port", prt_a, '1, 0);
      rchk("unmapped", 9'h1fc, '1, 0);
      bus(msk_a, 1'b1, 4'hf, 32'hffff_a5a5);
      rchk("mask", msk_a, '1, 32'ha5a5);
      bus(sum_a, 1'b1, 4'hf, 32'hffff_ffff);
      rchk("summary", sum_a, '1, 0);
      $display("regs done");
   endtask : t_regs
   task automatic t_irq;
      chan_done_i[3] <= 1'b1;
      chan_halted_i[14] <= 1'b1;
      cyc(1);
      chan_done_i <= '0;
      chan_halted_i <= '0;
      cyc(3);
      rchk("summary", sum_a, '1, 32'h4008);
      check("chan irq", chan_irq_o, 0);
      bus(msk_a, 1'b1, 4'hf, 32'h8);
      cyc(2);
      check("chan irq", chan_irq_o, 1);
      bus(evt_a + 9'hc, 1'b1, 4'hf, 32'h1);
      bus(evt_a + 9'h38, 1'b1, 4'hf, 32'h2);
      cyc(2);
      check("chan irq", chan_irq_o, 0);
      rchk("summary", sum_a, '1, 0);
      $display("irq test done");
   endtask : t_irq
   task automatic t_connect;
      for (int s = 1; s >= 0; s--) begin
         attach <= 1'b0;
         cyc(3);
         rchk("connect", prt_a, 32'h1, 0);
         slow <= s[0];
         attach <= 1'b1;
         cyc(4);
         check("port irq", port_irq_o, 1);
         rchk("girq", usb_host_port_pkg::OFS_GIRQ, 32'h2, 32'h2);
         rchk("port", prt_a, 32'h6_0c03, s ? 32'h4_0803 : 32'h2_0403);
         bus(prt_a, 1'b1, 4'h1, 32'h2a);
         cyc(2);
         check("port irq", port_irq_o, 0);
      end
      $display("connect test done");
   endtask : t_connect
   task automatic port_rst;
      bus(prt_a, 1'b1, 4'h2, 32'h1100);
      cyc(2);
      check("reset out", port_reset_o, 1);
      rchk("line", prt_a, 32'hc00, 0);
      cyc(20);
      bus(prt_a, 1'b1, 4'h2, 32'h1000);
      cyc(2);
      check("enabled", port_enabled_o, 1);
   endtask : port_rst
   task automatic t_port;
      bus(prt_a, 1'b1, 4'h1, 32'h4);
      cyc(2);
      check("enabled", port_enabled_o, 0);
      port_rst;
      check("power", port_power_o, 1);
      check("port irq", port_irq_o, 1);
      rchk("port", prt_a, 32'h110c, 32'h100c);
      bus(prt_a, 1'b1, 4'h1, 32'hc);
      rchk("port", prt_a, 32'hc, 32'h8);
      bus(prt_a, 1'b1, 4'h1, 32'h8);
      port_rst;
      overcurrent_i <= 1'b1;
      cyc(4);
      rchk("port", prt_a, 32'h3c, 32'h38);
      overcurrent_i <= 1'b0;
      cyc(3);
      bus(prt_a, 1'b1, 4'h1, 32'h28);
      rchk("port", prt_a, 32'h3c, 0);
      port_rst;
      $display("port test done");
   endtask : t_port
   task automatic t_test;
      for (int c = 5; c >= 0; c--) begin
         bus(prt_a, 1'b1, 4'h6, 32'h1000 | (c << 13));
         cyc(2);
         check("test select", port_test_o, c);
      end
      $display("test mode done");
   endtask : t_test
   task automatic t_suspend;
      bus(prt_a, 1'b1, 4'h1, 32'h80);
      cyc(2);
      check("suspend", port_suspend_o, 1);
      check("enabled", port_enabled_o, 1);
      wake_req <= 1'b1;
      cyc(1);
      wake_req <= 1'b0;
      cyc(10);
      rchk("port", prt_a, 32'hc0, 32'h40);
      bus(prt_a, 1'b1, 4'h1, 32'h0);
      cyc(2);
      check("resume", port_resume_o, 0);
      bus(prt_a, 1'b1, 4'h1, 32'h80);
      attach <= 1'b0;
      cyc(3);
      check("suspend", port_suspend_o, 0);
      attach <= 1'b1;
      cyc(4);
      $display("suspend test done");
   endtask : t_suspend
   task automatic t_chan;
      // enable, odd, addr 55, mc 3, interrupt, ls, in, ep a, mps 7ff; bit 16 reads zero
      bus(chr_a, 1'b1, 4'hf, 32'hb57f_d7ff);
      cyc(2);
      check("config", chan_cfg_o, 32'hb57e_d7ff);
      check("go", chan_go_o, 0);
      frame_odd_i <= 1'b1;
      cyc(2);
      check("go", chan_go_o, 32'h4);
      chan_done_i[2] <= 1'b1;
      cyc(1);
      chan_done_i <= '0;
      cyc(3);
      check("go", chan_go_o, 0);
      rchk("summary", sum_a, '1, 32'h4);
      bus(evt_a + 9'h8, 1'b1, 4'hf, 32'h1);
      for (int t = 0; t < 4; t++) begin
         bus(chr_a, 1'b1, 4'hf, 32'h8010_0000 | (t << 18));
         cyc(2);
         check("type", chan_cfg_o[19:18], t);
         check("go", chan_go_o, t[0] ? 0 : 32'h4);
      end
      bus(chr_a, 1'b1, 4'h8, 32'h4000_0000);
      cyc(2);
      check("abort", chan_abort_o, 32'h4);
      check("go", chan_go_o, 0);
      chan_halted_i[2] <= 1'b1;
      cyc(1);
      chan_halted_i <= '0;
      cyc(3);
      rchk("chars", chr_a, 32'hc000_0000, 0);
      rchk("summary", sum_a, '1, 32'h4);
      bus(evt_a + 9'h8, 1'b1, 4'hf, 32'h2);
      rchk("summary", sum_a, '1, 0);
      $display("channel test done");
   endtask : t_chan
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   // watchdog: tests need a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      report_and_stop;
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, overcurrent_i, frame_odd_i, attach, slow, wake_req} = '0;
      wb_adr_i = '0;
      wb_sel_i = '0;
      wb_dat_i = '0;
      chan_done_i = '0;
      chan_halted_i = '0;
      chan_sel_i = 4'h2; // only channel 2 is observed on chan_cfg_o
      rst_i = 1'b1;
      cyc(3);
      rst_i <= 1'b0;
      t_regs;
      t_irq;
      t_connect;
      t_port;
      t_test;
      t_suspend;
      t_chan;
      report_and_stop;
   end
endmodule : usb_host_port_channel_ctrl_tb
